// ### logic/boot_rom.sv
// Small bootstrap firmware ROM with registered read data.
`timescale 1ns/1ps
module boot_rom
  import intr_prio_pkg::*;
#(
  parameter logic [ROM_DEPTH*8-1:0] CONTENTS = '0
)
(
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic [7:0] i_addr,
  output logic      [7:0] o_data
);

  wire logic [7:0] word_sel = (i_addr < 8'(ROM_DEPTH)) ? CONTENTS[i_addr*8 +: 8] : 8'h00;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_data <= 8'h00;
    else
      o_data <= word_sel;
  end

endmodule

// ### logic/intr_prio_pkg.sv
// Package with register map, field layout, reset values and carrier types of the interrupt priority block.
// Overview of operation
// - Boot ROM enable at 1 maps the 192-byte boot ROM; 0 removes it.
// - Boot ROM absent outside bootstrap mode; enable is 0 out of reset in test mode.
// - Boot ROM enable is writable only while the special-mode flag is 1.
// - Special-mode flag may be written to 0 anytime, never back to 1.
// - Mode A select is writable only while the special-mode flag is 1.
// - Read visibility writable only in special mode, forced 0 when flag is 0.
// - Read visibility drives internal read data onto the external bus during reads.
// - Priority select field is writable only while the maskable mask bit is 1.
// - Promoted source ranks first among maskable sources; nonmaskable still wins.
// - Codes 0 to 7 promote timer, accumulator, SPI, SCI, IRQ and real-time sources.
// - Codes 8 to 15 promote input captures 1-3 then output compares 1-5.
// - Reserved code 0101 promotes the external IRQ source.
// - Return unstacks every saved register, program counter last.
// - Nonmaskable mask clears only by condition code transfer or unstacked 0.
// - Nonmaskable mask is set only by reset or nonmaskable acknowledge.
// - Nonmaskable service stacks condition codes with mask clear, then sets mask.
// - Nonmaskable mask is a set-reset flop: set reset/ack, clear on bit 6 zero.
// - Writing or unstacking 1 into that bit leaves it unchanged.
// - Stop mode ends on reset, external maskable request or nonmaskable request.
// - Nonmaskable wake with mask 0 gives full stacking and normal service.
// - Nonmaskable wake with mask 1 restarts clocks and continues after stop.
// - Upper nibble writable in special modes, lower nibble while maskable mask is 1.
// - Promoted source still obeys local enable and maskable mask; vector unchanged.
// - Maskable entry sets maskable mask after stacking condition codes, nonmaskable untouched.
package intr_prio_pkg;

  localparam logic [7:0] HPM_OFFSET      = 8'h00;
  localparam logic [7:0] STATUS_OFFSET   = 8'h04;
  localparam logic [7:0] ENABLE_OFFSET   = 8'h08;
  localparam int         BOOT_EN_BIT     = 7;
  localparam int         SPECIAL_BIT     = 6;
  localparam int         MODE_A_BIT      = 5;
  localparam int         IRV_BIT         = 4;
  localparam int         CCR_X_BIT       = 6;
  localparam int         CCR_I_BIT       = 4;
  localparam logic [3:0] PSEL_RESET      = 4'h6;
  localparam logic [3:0] PSEL_RESERVED   = 4'h5;
  localparam logic [3:0] SRC_EXT_IRQ     = 4'h6;
  localparam logic [15:0] ENABLE_RESET   = 16'h0000;
  localparam int         NUM_SRC         = 16;
  localparam int         ROM_DEPTH       = 192;
  localparam logic [15:0] ROM_BASE       = 16'hBF40;
  localparam logic [3:0] ITEM_CCR        = 4'h8;
  localparam logic [3:0] ITEM_PCL        = 4'h0;
  localparam logic [63:0] DEFAULT_RANK   = 64'h0123_4567_89AB_CDEF;

  typedef enum {ST_BOOT, ST_RUN, ST_STACK, ST_VECTOR, ST_UNSTACK, ST_STOP} seq_state_t;

  typedef struct packed {
    logic       special;
    logic       mode_a;
  } mode_pins_t;

  typedef struct packed {
    logic       tap_write;
    logic [7:0] tap_data;
    logic       insn_done;
    logic       rti_start;
    logic       stop_exec;
    logic [7:0] pull_data;
  } cpu_evt_t;

  typedef struct packed {
    logic       push;
    logic       pull;
    logic [3:0] item;
  } seq_out_t;

  typedef struct packed {
    logic       valid;
    logic       nmi;
    logic [3:0] src;
  } vector_t;

endpackage

// ### logic/intr_prio_top.sv
// Interrupt priority, mode register, nonmaskable mask and stack sequencing of the core.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module intr_prio_top
  import intr_prio_pkg::*;
#(
  parameter logic [63:0]            RANK     = DEFAULT_RANK,
  parameter logic [ROM_DEPTH*8-1:0] ROM_DATA = '0
)
(
  input  wire logic               i_clk,
  input  wire logic               i_arst_n,
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [7:0]         i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic      [31:0]        o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  input  wire mode_pins_t         i_mode,
  input  wire logic [NUM_SRC-1:0] i_src_req,
  input  wire logic               i_nonmaskable_request_pin_n,
  input  wire cpu_evt_t           i_cpu,
  input  wire logic [15:0]        i_cpu_addr,
  input  wire logic               i_internal_read,
  input  wire logic [7:0]         i_internal_rdata,
  output logic                    o_core_ready,
  output logic                    o_int_pending,
  output seq_out_t                o_seq,
  output logic                    o_x_mask,
  output logic                    o_i_mask,
  output vector_t                 o_vector,
  output logic                    o_stop_continue,
  output logic                    o_clocks_run,
  output logic                    o_resume,
  output logic                    o_boot_hit,
  output logic      [7:0]         o_boot_data,
  output logic      [7:0]         o_ext_data_out,
  output logic                    o_ext_data_oe
);

  // Register state.
  logic             boot_en_r;
  logic             special_r;
  logic             mode_a_r;
  logic             irv_r;
  logic [3:0]       psel_r;
  logic [15:0]      enable_r;
  logic             x_r;
  logic             i_r;
  seq_state_t       state_r;
  seq_state_t       state_nxt;
  logic [3:0]       item_r;
  logic [3:0]       item_nxt;
  logic             serve_nmi_r;
  vector_t          vector_r;
  logic             stop_cont_r;
  logic             resume_r;
  logic [7:0]       ext_data_r;
  logic             ext_oe_r;
  logic [31:0]      prdata_r;

  // Bus decode.
  wire logic        apb_access = i_psel & i_penable;
  wire logic        apb_wr     = apb_access & i_pwrite;
  wire logic        hit_hpm    = (i_paddr == HPM_OFFSET);
  wire logic        hit_status = (i_paddr == STATUS_OFFSET);
  wire logic        hit_enable = (i_paddr == ENABLE_OFFSET);
  wire logic        mapped     = hit_hpm | hit_status | hit_enable;
  wire logic        wr_hpm     = apb_wr & hit_hpm;
  wire logic        wr_enable  = apb_wr & hit_enable;

  // Request qualification.
  wire logic        nmi_req     = ~i_nonmaskable_request_pin_n;
  wire logic [NUM_SRC-1:0] masked_req = i_src_req & enable_r;
  wire logic        res_valid;
  wire logic [3:0]  res_src;
  wire logic        nmi_pending = nmi_req & ~x_r;
  wire logic        irq_pending = res_valid & ~i_r;
  wire logic        ext_irq_req = i_src_req[SRC_EXT_IRQ];
  wire logic        any_pending = nmi_pending | irq_pending;

  // Sequencer events.
  wire logic        in_stack    = (state_r == ST_STACK);
  wire logic        in_unstack  = (state_r == ST_UNSTACK);
  wire logic        ccr_stacked = in_stack & (item_r == ITEM_CCR);
  wire logic        ccr_pulled  = in_unstack & (item_r == ITEM_CCR);
  wire logic        nmi_ack     = ccr_stacked & nmi_pending;
  // A maskable entry needs no acknowledge term: stacking the flags byte sets I for any source.
  wire logic        wake_nmi    = (state_r == ST_STOP) & nmi_req;
  wire logic        wake_irq    = (state_r == ST_STOP) & ext_irq_req;
  wire logic        ccr_load    = i_cpu.tap_write | ccr_pulled;
  wire logic [7:0]  ccr_data    = i_cpu.tap_write ? i_cpu.tap_data : i_cpu.pull_data;

  // The set term stands above the clear term so an acknowledge is never lost.
  wire logic        x_set   = nmi_ack;
  wire logic        x_clear = ccr_load & ~ccr_data[CCR_X_BIT];

  // Writable fields of the priority and miscellaneous register.
  wire logic        wr_upper     = wr_hpm & special_r;
  wire logic        wr_lower     = wr_hpm & i_r;
  wire logic        special_nxt  = wr_hpm ? (special_r & i_pwdata[SPECIAL_BIT]) : special_r;
  wire logic        boot_en_nxt  = wr_upper ? i_pwdata[BOOT_EN_BIT] : boot_en_r;
  wire logic        mode_a_nxt   = wr_upper ? i_pwdata[MODE_A_BIT] : mode_a_r;
  wire logic        irv_wr_val   = wr_upper ? i_pwdata[IRV_BIT] : irv_r;
  wire logic        irv_nxt      = irv_wr_val & special_nxt;
  wire logic [3:0]  psel_nxt     = wr_lower ? i_pwdata[3:0] : psel_r;
  wire logic [7:0]  hpm_value    = {boot_en_r, special_r, mode_a_r, irv_r, psel_r};
  wire logic [31:0] status_value = {21'h00000, vector_r.src, 2'h0, any_pending,
                                    (state_r == ST_STOP), i_r, x_r, 1'h0};

  // Boot ROM window and read visibility.
  wire logic [15:0] rom_offset  = i_cpu_addr - ROM_BASE;
  wire logic        rom_in_win  = (i_cpu_addr >= ROM_BASE);
  wire logic        rom_sel     = boot_en_r & rom_in_win;
  wire logic        show_read   = irv_r & i_internal_read;

  prio_resolver #(
    .RANK     (RANK)
  ) u_resolver (
    .i_req    (masked_req),
    .i_psel   (psel_r),
    .o_valid  (res_valid),
    .o_src    (res_src)
  );

  boot_rom #(
    .CONTENTS (ROM_DATA)
  ) u_boot_rom (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_addr   (rom_offset[7:0]),
    .o_data   (o_boot_data)
  );

  // Next state of the entry, return and stop sequencer.
  always_comb
  begin
    state_nxt = state_r;
    item_nxt  = item_r;
    case (state_r)
      ST_BOOT:
        state_nxt = ST_RUN;
      ST_RUN:
        if (i_cpu.insn_done && any_pending)
        begin
          state_nxt = ST_STACK;
          item_nxt  = ITEM_PCL;
        end
        else if (i_cpu.rti_start)
        begin
          state_nxt = ST_UNSTACK;
          item_nxt  = ITEM_CCR;
        end
        else if (i_cpu.stop_exec)
          state_nxt = ST_STOP;
      ST_STACK:
        if (item_r == ITEM_CCR)
          state_nxt = ST_VECTOR;
        else
          item_nxt = item_r + 4'h1;
      ST_VECTOR:
        state_nxt = ST_RUN;
      ST_UNSTACK:
        if (item_r == ITEM_PCL)
          state_nxt = ST_RUN;
        else
          item_nxt = item_r - 4'h1;
      ST_STOP:
        if ((wake_nmi && !x_r) || (wake_irq && !i_r))
        begin
          state_nxt = ST_STACK;
          item_nxt  = ITEM_PCL;
        end
        else if (wake_nmi || wake_irq)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  // Mode bits are caught from the pins at the first edge after reset release.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      special_r <= 1'b0;
      mode_a_r  <= 1'b0;
      boot_en_r <= 1'b0;
      irv_r     <= 1'b0;
      psel_r    <= PSEL_RESET;
    end
    else if (state_r == ST_BOOT)
    begin
      special_r <= i_mode.special;
      mode_a_r  <= i_mode.mode_a;
      boot_en_r <= i_mode.special & ~i_mode.mode_a;
      irv_r     <= 1'b0;
    end
    else
    begin
      special_r <= special_nxt;
      mode_a_r  <= mode_a_nxt;
      boot_en_r <= boot_en_nxt;
      irv_r     <= irv_nxt;
      psel_r    <= psel_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      enable_r <= ENABLE_RESET;
    else if (wr_enable)
      enable_r <= i_pwdata[15:0];
  end

  // Mask bits: X is set-reset, I follows writes and is set on every entry.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      x_r <= 1'b1;
      i_r <= 1'b1;
    end
    else
    begin
      if (x_set)
        x_r <= 1'b1;
      else if (x_clear)
        x_r <= 1'b0;
      if (ccr_stacked)
        i_r <= 1'b1;
      else if (ccr_load)
        i_r <= ccr_data[CCR_I_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_r <= ST_BOOT;
      item_r  <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      item_r  <= item_nxt;
    end
  end

  // Resolution runs after condition codes are stacked, so a later stronger source wins.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      serve_nmi_r <= 1'b0;
    else if (ccr_stacked)
      serve_nmi_r <= nmi_pending;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      vector_r <= '0;
    else if (state_r == ST_VECTOR)
      vector_r <= '{valid: 1'b1, nmi: serve_nmi_r, src: res_src};
    else
      vector_r.valid <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      stop_cont_r <= 1'b0;
      resume_r    <= 1'b0;
    end
    else
    begin
      stop_cont_r <= (state_r == ST_STOP) && (state_nxt == ST_RUN);
      resume_r    <= in_unstack && (item_r == ITEM_PCL);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ext_data_r <= 8'h00;
      ext_oe_r   <= 1'b0;
    end
    else
    begin
      ext_data_r <= i_internal_rdata;
      ext_oe_r   <= show_read;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      prdata_r <= 32'h0000_0000;
    else if (i_psel && !i_penable && !i_pwrite)
      prdata_r <= hit_hpm ? {24'h000000, hpm_value} :
                  hit_status ? status_value :
                  hit_enable ? {16'h0000, enable_r} : 32'h0000_0000;
  end

  // Zero wait states; read data is captured in the setup cycle.
  assign o_pready        = 1'b1;
  assign o_pslverr       = apb_access & ~mapped;
  assign o_prdata        = prdata_r;
  assign o_core_ready    = (state_r != ST_BOOT);
  assign o_int_pending   = any_pending & (state_r == ST_RUN);
  assign o_seq.push      = in_stack;
  assign o_seq.pull      = in_unstack;
  assign o_seq.item      = item_r;
  // Nonmaskable service only starts with X at 0, so its stacked byte carries X clear.
  assign o_x_mask        = x_r;
  assign o_i_mask        = i_r;
  assign o_vector        = vector_r;
  assign o_stop_continue = stop_cont_r;
  assign o_clocks_run    = (state_r != ST_STOP);
  assign o_resume        = resume_r;
  assign o_boot_hit      = rom_sel & (rom_offset < 16'(ROM_DEPTH));
  assign o_ext_data_out  = ext_data_r;
  assign o_ext_data_oe   = ext_oe_r;

endmodule

// ### logic/prio_resolver.sv
// Fixed-order maskable priority chain with one promotable source.
`timescale 1ns/1ps
module prio_resolver
  import intr_prio_pkg::*;
#(
  parameter logic [63:0] RANK = DEFAULT_RANK
)
(
  input  wire logic [NUM_SRC-1:0] i_req,
  input  wire logic [3:0]         i_psel,
  output logic                    o_valid,
  output logic      [3:0]         o_src
);

  wire logic [3:0]   promoted = (i_psel == PSEL_RESERVED) ? SRC_EXT_IRQ : i_psel;
  logic [NUM_SRC:0]  taken;
  logic [3:0]        pick [NUM_SRC:0];

  assign taken[0] = i_req[promoted];
  assign pick[0]  = promoted;

  // Earlier ranks keep their pick; the first requesting rank fills an empty slot.
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_rank
      wire logic [3:0] idx = RANK[63-4*g -: 4];
      assign taken[g+1] = taken[g] | i_req[idx];
      assign pick[g+1]  = taken[g] ? pick[g] : idx;
    end
  endgenerate

  assign o_valid = taken[NUM_SRC];
  assign o_src   = pick[NUM_SRC];

endmodule

// ### verif/cpu_pull_model.sv
// Behavioural model of the CPU side that hands unstacked bytes to the block.
`timescale 1ns/1ps
module cpu_pull_model
  import intr_prio_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire seq_out_t   i_seq,
  input  wire logic [7:0] i_img,
  output logic      [7:0] o_pull_data
);
  logic [7:0] junk_r;
  // Off the condition code slot the byte churns every cycle, so a stale sample shows up.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      junk_r <= 8'hA5;
    else
      junk_r <= ~junk_r;
  end
  assign o_pull_data = (i_seq.pull && i_seq.item == ITEM_CCR) ? i_img : junk_r;
endmodule

// ### verif/intr_prio_top_assertions.sv
// Concurrent checks on the ports of the interrupt priority block.
`timescale 1ns/1ps
module intr_prio_top_checker
  import intr_prio_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire cpu_evt_t   i_cpu,
  input wire logic       i_internal_read,
  input wire logic [7:0] i_internal_rdata,
  input wire seq_out_t   o_seq,
  input wire logic       o_x_mask,
  input wire logic       o_i_mask,
  input wire vector_t    o_vector,
  input wire logic       o_stop_continue,
  input wire logic       o_clocks_run,
  input wire logic       o_resume,
  input wire logic [7:0] o_ext_data_out,
  input wire logic       o_ext_data_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_x_set;
    $rose(o_x_mask) |=> o_vector.valid && o_vector.nmi;
  endproperty
  a_x_set: assert property (p_x_set) else $error("X mask set without service");
  property p_x_clr;
    $fell(o_x_mask) |-> $past(i_cpu.tap_write && !i_cpu.tap_data[CCR_X_BIT]) ||
      $past(o_seq.pull && o_seq.item == ITEM_CCR && !i_cpu.pull_data[CCR_X_BIT]);
  endproperty
  a_x_clr: assert property (p_x_clr) else $error("X mask cleared by no zero");
  property p_nmi_vec;
    o_vector.valid && o_vector.nmi |-> o_x_mask && o_i_mask;
  endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("NMI entry masks");
  property p_irq_vec;
    o_vector.valid && !o_vector.nmi |-> o_i_mask && o_x_mask == $past(o_x_mask, 3);
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("maskable entry masks");
  property p_push;
    o_seq.push && o_seq.item != ITEM_CCR |=> o_seq.push && o_seq.item == $past(o_seq.item) + 4'h1;
  endproperty
  a_push: assert property (p_push) else $error("push order");
  property p_pull;
    o_seq.pull && o_seq.item != ITEM_PCL |=> o_seq.pull && o_seq.item == $past(o_seq.item) - 4'h1;
  endproperty
  a_pull: assert property (p_pull) else $error("pull order");
  property p_stop_cont;
    o_stop_continue |-> !o_vector.valid && o_clocks_run && !$past(o_clocks_run);
  endproperty
  a_stop_cont: assert property (p_stop_cont) else $error("stop continue");
  property p_irv;
    o_ext_data_oe |-> $past(i_internal_read) && o_ext_data_out == $past(i_internal_rdata);
  endproperty
  a_irv: assert property (p_irv) else $error("read visibility data");
  cover property (o_vector.valid && o_vector.nmi);
  cover property (o_stop_continue);
  cover property (o_resume);
endmodule

bind intr_prio_top intr_prio_top_checker u_chk (
  .i_clk(i_clk),
  .i_arst_n(i_arst_n),
  .i_cpu(i_cpu),
  .i_internal_read(i_internal_read),
  .i_internal_rdata(i_internal_rdata),
  .o_seq(o_seq),
  .o_x_mask(o_x_mask),
  .o_i_mask(o_i_mask),
  .o_vector(o_vector),
  .o_stop_continue(o_stop_continue),
  .o_clocks_run(o_clocks_run),
  .o_resume(o_resume),
  .o_ext_data_out(o_ext_data_out),
  .o_ext_data_oe(o_ext_data_oe)
);

// ### verif/intr_prio_top_tb.sv
// Self-checking bench of the interrupt priority block.
`timescale 1ns/1ps
module intr_prio_top_tb;
  import intr_prio_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] src_req = 16'h0;
  logic        nmi_n = 1'b1;
  logic [15:0] cpu_addr = 16'h0;
  logic        ird = 1'b0;
  logic [7:0]  irdata = 8'h00;
  logic [7:0]  img = 8'h00;
  cpu_evt_t    cpu_r = '0;
  cpu_evt_t    cpu_in;
  mode_pins_t  mode = '{special: 1'b1, mode_a: 1'b0};
  logic [7:0]  pull;
  logic [31:0] prdata;
  logic        pready, pslverr, xm, im, stop_cont, clk_run, resume, boot_hit, oe;
  seq_out_t    seq;
  vector_t     vec;
  logic [7:0]  ext_out;
  logic [7:0]  boot_data;
  logic        cready, ipend;
  localparam logic [ROM_DEPTH*8-1:0] ROM_IMG = {ROM_DEPTH{8'h3C}};
  logic [31:0] rd;
  logic        er;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #12.5 clk = ~clk;

  always_comb
  begin
    cpu_in = cpu_r;
    cpu_in.pull_data = pull;
  end

  intr_prio_top #(.ROM_DATA(ROM_IMG)) dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_mode(mode), .i_src_req(src_req),
    .i_nonmaskable_request_pin_n(nmi_n), .i_cpu(cpu_in), .i_cpu_addr(cpu_addr),
    .i_internal_read(ird), .i_internal_rdata(irdata), .o_core_ready(cready),
    .o_int_pending(ipend), .o_seq(seq), .o_x_mask(xm), .o_i_mask(im), .o_vector(vec),
    .o_stop_continue(stop_cont), .o_clocks_run(clk_run), .o_resume(resume),
    .o_boot_hit(boot_hit), .o_boot_data(boot_data), .o_ext_data_out(ext_out),
    .o_ext_data_oe(oe)
  );

  cpu_pull_model u_cpu (
    .i_clk(clk), .i_arst_n(arst_n), .i_seq(seq), .i_img(img), .o_pull_data(pull)
  );

  task automatic stop_test();
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    apb(1'b1, a, d);
    apb(1'b0, a, 32'h0);
    chk(rd, e, "register readback");
  endtask

  // Kinds: 0 flag transfer, 1 instruction end, 2 return, 3 stop.
  task automatic ev(input int k, input logic [7:0] d);
    @(posedge clk);
    cpu_r.tap_write <= (k == 0);
    cpu_r.insn_done <= (k == 1);
    cpu_r.rti_start <= (k == 2);
    cpu_r.stop_exec <= (k == 3);
    cpu_r.tap_data <= d;
    @(posedge clk);
    cpu_r <= '0;
    @(negedge clk);
  endtask

  task automatic wait_for(input int k);
    int n;
    n = 0;
    while (n < 40 && (k == 0 ? vec.valid : k == 1 ? stop_cont : resume) !== 1'b1)
    begin
      @(negedge clk);
      n++;
    end
    chk(n < 40, 1'b1, "handshake wait");
  endtask

  task automatic take(input logic [3:0] s);
    chk(ipend, 1'b1, "interrupt pending");
    ev(1, 8'h00);
    wait_for(0);
    chk(vec.src, s, "vector source");
    chk(vec.nmi, 1'b0, "vector kind");
  endtask

  task automatic rom(input logic [15:0] a, input logic e);
    @(posedge clk);
    cpu_addr <= a;
    @(negedge clk);
    chk(boot_hit, e, "rom decode");
    @(negedge clk);
    if (e)
      chk(boot_data, 8'h3C, "rom data");
  endtask

  task automatic vis(input logic e);
    @(posedge clk);
    ird <= 1'b1;
    irdata <= 8'h5A;
    @(posedge clk);
    ird <= 1'b0;
    @(negedge clk);
    chk(oe, e, "visibility enable");
    if (e)
      chk(ext_out, 8'h5A, "visibility data");
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      stop_test();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(cready, 1'b1, "core ready");
    apb(1'b0, HPM_OFFSET, 32'h0);
    chk(rd, 32'hC6, "reset value");
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h6, "status reset");
    chk({xm, im}, 2'b11, "reset masks");
    rom(ROM_BASE, 1'b1);
    rom(16'hBFFF, 1'b1);
    rom(16'hBF3F, 1'b0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(er, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    wrd(HPM_OFFSET, 32'hF3, 32'hF3);
    vis(1'b1);
    wrd(HPM_OFFSET, 32'h03, 32'h03);
    rom(ROM_BASE, 1'b0);
    wrd(HPM_OFFSET, 32'hF9, 32'h09);
    vis(1'b0);
    ev(0, 8'h00);
    chk({xm, im}, 2'b00, "masks cleared");
    wrd(HPM_OFFSET, 32'h07, 32'h09);
    ev(0, 8'h50);
    chk({xm, im}, 2'b01, "x held");
    wrd(ENABLE_OFFSET, 32'hFFFF, 32'hFFFF);
    for (int c = 0; c < 16; c++)
    begin
      wrd(HPM_OFFSET, 32'(c), 32'(c));
      src_req <= (16'h1 << ((c == 5) ? 6 : c)) | ((c == 0) ? 16'h8000 : 16'h0001);
      ev(0, 8'h00);
      take((c == 5) ? 4'h6 : 4'(c));
      chk({xm, im, ipend}, 3'b010, "entry masks");
      @(posedge clk);
      src_req <= 16'h0;
    end
    wrd(ENABLE_OFFSET, 32'hFFF7, 32'hFFF7);
    wrd(HPM_OFFSET, 32'h03, 32'h03);
    src_req <= 16'h8008;
    ev(0, 8'h00);
    take(4'hF);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h784, "status after entry");
    @(posedge clk);
    src_req <= 16'h0001;
    ev(3, 8'h00);
    chk(clk_run, 1'b0, "stopped");
    @(posedge clk);
    nmi_n <= 1'b0;
    wait_for(0);
    chk(vec.nmi, 1'b1, "nonmaskable wins");
    chk({xm, im}, 2'b11, "nonmaskable entry masks");
    @(posedge clk);
    nmi_n <= 1'b1;
    ev(3, 8'h00);
    @(posedge clk);
    nmi_n <= 1'b0;
    wait_for(1);
    chk({clk_run, vec.valid, xm}, 3'b101, "stop continue");
    @(posedge clk);
    nmi_n <= 1'b1;
    ev(3, 8'h00);
    @(posedge clk);
    src_req <= 16'h0040;
    wait_for(1);
    @(posedge clk);
    src_req <= 16'h0;
    img <= 8'h40;
    ev(2, 8'h00);
    wait_for(2);
    chk({xm, im}, 2'b10, "unstack one");
    @(posedge clk);
    img <= 8'h10;
    ev(2, 8'h00);
    wait_for(2);
    chk({xm, im}, 2'b01, "unstack zero");
    mode <= '{special: 1'b1, mode_a: 1'b1};
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(cready, 1'b0, "core held in reset");
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, HPM_OFFSET, 32'h0);
    chk(rd, 32'h66, "test mode reset");
    rom(ROM_BASE, 1'b0);
    stop_test();
  end
endmodule
